// File: shared/tpd_pkg.sv
// Shared constants and decoders for the timestamp, reference output and feedback divider registers.
package tpd_pkg;

  localparam int unsigned ADDR_W     = 15;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned HEAD_BITS  = 16;

  localparam logic [14:0] STAMP_CTRL_ADDR = 15'h003b;
  localparam logic [14:0] REFOUT_ADDR     = 15'h003c;
  localparam logic [14:0] FBDIV_A_ADDR    = 15'h003d;
  localparam logic [14:0] FBDIV_B_ADDR    = 15'h003e;

  localparam logic [7:0] STAMP_CTRL_RST = 8'h00;
  localparam logic [7:0] REFOUT_RST     = 8'h01;
  localparam logic [7:0] FBDIV_A_RST    = 8'h00;
  localparam logic [7:0] FBDIV_B_RST    = 8'h20;

  localparam int unsigned RECV_ON_BIT   = 0;
  localparam int unsigned PECL_BIT      = 1;
  localparam int unsigned REFOUT_EN_BIT = 0;
  localparam int unsigned VDIV_LSB      = 0;
  localparam int unsigned PDIV_LSB      = 2;
  localparam int unsigned NDIV_LSB      = 0;

  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Reserved code 3 falls back to the default ratio so the loop never stops.
  function automatic logic [2:0] tpd_vlen(input logic [1:0] sel);
    unique case (sel)
      2'h1:    tpd_vlen = 3'h4;
      2'h2:    tpd_vlen = 3'h3;
      default: tpd_vlen = 3'h5;
    endcase
  endfunction

  function automatic logic [2:0] tpd_plen(input logic [1:0] sel);
    unique case (sel)
      2'h1:    tpd_plen = 3'h2;
      2'h2:    tpd_plen = 3'h4;
      default: tpd_plen = 3'h1;
    endcase
  endfunction

  // A programmed zero is treated as divide-by-1.
  function automatic logic [5:0] tpd_nlen(input logic [5:0] val);
    tpd_nlen = (val == 6'h00) ? 6'h01 : val;
  endfunction

endpackage

// File: hdl/tpd_fb_divider.sv
// Three-stage feedback divider chain producing sampling and feedback ticks.
`timescale 1ns/1ps
`default_nettype none
module tpd_fb_divider (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clkEn,
  input  wire logic       holdReset,
  input  wire logic [1:0] vSel,
  input  wire logic [1:0] pSel,
  input  wire logic [5:0] nDiv,
  output logic            sampleTick,
  output logic            feedbackTick
);

  logic [2:0] vCnt_reg;
  logic [2:0] vCnt_next;
  logic [1:0] pCnt_reg;
  logic [1:0] pCnt_next;
  logic [5:0] nCnt_reg;
  logic [5:0] nCnt_next;
  logic       sample_reg;
  logic       sample_next;
  logic       feedback_reg;
  logic       feedback_next;
  logic [2:0] vLen;
  logic [2:0] pLen;
  logic [5:0] nLen;
  logic       vWrap;
  logic       pWrap;
  logic       nWrap;

  always_comb
  begin
    vLen = tpd_pkg::tpd_vlen(vSel);
    pLen = tpd_pkg::tpd_plen(pSel);
    nLen = tpd_pkg::tpd_nlen(nDiv);
    vWrap = (vCnt_reg == vLen - 3'h1);
    pWrap = vWrap && ({1'b0, pCnt_reg} == pLen - 3'h1);
    nWrap = pWrap && (nCnt_reg == nLen - 6'h01);
    vCnt_next = vWrap ? 3'h0 : vCnt_reg + 3'h1;
    pCnt_next = pWrap ? 2'h0 : (vWrap ? pCnt_reg + 2'h1 : pCnt_reg);
    nCnt_next = nWrap ? 6'h00 : (pWrap ? nCnt_reg + 6'h01 : nCnt_reg);
    sample_next = pWrap;
    feedback_next = nWrap;
    if (holdReset)
    begin
      vCnt_next = 3'h0;
      pCnt_next = 2'h0;
      nCnt_next = 6'h00;
      sample_next = 1'b0;
      feedback_next = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      vCnt_reg <= 3'h0;
      pCnt_reg <= 2'h0;
      nCnt_reg <= 6'h00;
      sample_reg <= 1'b0;
      feedback_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      vCnt_reg <= vCnt_next;
      pCnt_reg <= pCnt_next;
      nCnt_reg <= nCnt_next;
      sample_reg <= sample_next;
      feedback_reg <= feedback_next;
    end
  end

  assign sampleTick = sample_reg;
  assign feedbackTick = feedback_reg;

  // Checker helpers: enabled cycles between sample ticks, sample ticks per feedback tick.
  logic [4:0] gapCnt;
  logic       gapSeen;
  logic [6:0] perFb;
  logic       fbSeen;

  always_ff @(posedge clk)
  begin
    if (!resetn || holdReset)
    begin
      gapCnt <= 5'h00;
      gapSeen <= 1'b0;
      perFb <= 7'h00;
      fbSeen <= 1'b0;
    end
    else if (clkEn)
    begin
      gapCnt <= sample_reg ? 5'h00 : gapCnt + 5'h01;
      gapSeen <= gapSeen | sample_reg;
      perFb <= feedback_reg ? {6'h00, sample_next} : perFb + {6'h00, sample_next};
      fbSeen <= fbSeen | feedback_reg;
    end
  end

  chk_sample_period: assert property (@(posedge clk) disable iff (!resetn)
    (clkEn && sampleTick && gapSeen && !holdReset) |->
      ({3'h0, gapCnt} + 8'h01 == {5'h00, vLen} * {5'h00, pLen}))
    else $error("Sampling tick spacing differs from V times P.");

  chk_v_range: assert property (@(posedge clk) disable iff (!resetn)
    vCnt_reg < vLen)
    else $error("First divider count exceeds its ratio.");

  chk_feedback_ratio: assert property (@(posedge clk) disable iff (!resetn)
    (clkEn && feedback_next && fbSeen && !holdReset) |-> (perFb + 7'h01 == {1'b0, nLen}))
    else $error("Feedback tick does not follow N sampling ticks.");

  chk_hold_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (clkEn && holdReset) |=> (!sampleTick && !feedbackTick && vCnt_reg == 3'h0))
    else $error("Divider chain ran while held in reset.");

  cov_feedback_tick: cover property (@(posedge clk) disable iff (!resetn) feedbackTick);

endmodule
`default_nettype wire

// File: hdl/tpd_regs.sv
// Serial-port register bank for timestamp input, reference output and feedback dividers.
`timescale 1ns/1ps
`default_nettype none
module tpd_regs (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clkEn,
  input  wire logic spiSclk,
  input  wire logic spiSelN,
  input  wire logic spiSdi,
  output logic      spiSdo,
  output logic      spiSdoOe,
  input  wire logic pllEnable,
  input  wire logic synthLoopReset,
  output logic      stampReceiverOn,
  output logic      stampPeclModeSel,
  output logic      stampSelfBiasOn,
  output logic      refoutEnable,
  output logic      sampleTick,
  output logic      feedbackTick
);

  typedef enum logic [0:0] {
    SPI_IDLE  = 1'b0,
    SPI_FRAME = 1'b1
  } tpd_spi_e;

  // Pin synchronisers: stage one is read only by stage two.
  logic [2:0] sclkSync;
  logic [1:0] selSync;
  logic [1:0] sdiSync;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sclkSync <= 3'h0;
      selSync <= 2'h3;
      sdiSync <= 2'h0;
    end
    else if (clkEn)
    begin
      sclkSync <= {sclkSync[1:0], spiSclk};
      selSync <= {selSync[0], spiSelN};
      sdiSync <= {sdiSync[0], spiSdi};
    end
  end

  logic sclkRise;
  logic sclkFall;
  logic selected;

  assign sclkRise = sclkSync[1] && !sclkSync[2];
  assign sclkFall = !sclkSync[1] && sclkSync[2];
  assign selected = !selSync[1];

  tpd_spi_e   state_reg;
  tpd_spi_e   state_next;
  logic [4:0] bitCnt_reg;
  logic [4:0] bitCnt_next;
  logic [22:0] shift_reg;
  logic [22:0] shift_next;
  logic [7:0] outSh_reg;
  logic [7:0] outSh_next;
  logic       sdo_reg;
  logic       sdo_next;
  logic       sdoOe_reg;
  logic       sdoOe_next;
  logic [7:0] stamp_reg;
  logic [7:0] stamp_next;
  logic [7:0] refout_reg;
  logic [7:0] refout_next;
  logic [7:0] divA_reg;
  logic [7:0] divA_next;
  logic [7:0] divB_reg;
  logic [7:0] divB_next;
  logic [7:0] readData;
  logic [14:0] headAddr;
  logic       isRead;

  // Frame: read flag, 15-bit address, 8 data bits, MSB first, sampled on rising SCLK.
  assign isRead = shift_reg[14];
  assign headAddr = {shift_reg[13:0], sdiSync[1]};

  always_comb
  begin
    unique case (headAddr)
      tpd_pkg::STAMP_CTRL_ADDR: readData = stamp_reg;
      tpd_pkg::REFOUT_ADDR:     readData = refout_reg;
      tpd_pkg::FBDIV_A_ADDR:    readData = divA_reg;
      tpd_pkg::FBDIV_B_ADDR:    readData = divB_reg;
      default:                  readData = tpd_pkg::READ_UNMAPPED;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;
    outSh_next = outSh_reg;
    sdo_next = sdo_reg;
    sdoOe_next = sdoOe_reg;
    stamp_next = stamp_reg;
    refout_next = refout_reg;
    divA_next = divA_reg;
    divB_next = divB_reg;
    unique case (state_reg)
      SPI_IDLE:
      begin
        bitCnt_next = 5'h00;
        sdoOe_next = 1'b0;
        if (selected)
        begin
          state_next = SPI_FRAME;
        end
      end
      SPI_FRAME:
      begin
        if (!selected)
        begin
          state_next = SPI_IDLE;
          sdoOe_next = 1'b0;
        end
        else if (sclkRise && bitCnt_reg < 5'(tpd_pkg::FRAME_BITS))
        begin
          shift_next = {shift_reg[21:0], sdiSync[1]};
          bitCnt_next = bitCnt_reg + 5'h01;
          if (bitCnt_reg == 5'(tpd_pkg::HEAD_BITS - 1) && isRead)
          begin
            outSh_next = readData;
            sdoOe_next = 1'b1;
          end
          // Writes land only on a complete frame; a short frame changes nothing.
          if (bitCnt_reg == 5'(tpd_pkg::FRAME_BITS - 1) && !shift_reg[22])
          begin
            // Every bit, reserved ones included, is stored as written.
            unique case (shift_reg[21:7])
              tpd_pkg::STAMP_CTRL_ADDR: stamp_next = {shift_reg[6:0], sdiSync[1]};
              tpd_pkg::REFOUT_ADDR:     refout_next = {shift_reg[6:0], sdiSync[1]};
              tpd_pkg::FBDIV_A_ADDR:    divA_next = {shift_reg[6:0], sdiSync[1]};
              tpd_pkg::FBDIV_B_ADDR:    divB_next = {shift_reg[6:0], sdiSync[1]};
              default:                  stamp_next = stamp_reg;
            endcase
          end
        end
        else if (sclkFall && sdoOe_reg)
        begin
          sdo_next = outSh_reg[7];
          outSh_next = {outSh_reg[6:0], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= SPI_IDLE;
      bitCnt_reg <= 5'h00;
      shift_reg <= 23'h000000;
      outSh_reg <= 8'h00;
      sdo_reg <= 1'b0;
      sdoOe_reg <= 1'b0;
      stamp_reg <= tpd_pkg::STAMP_CTRL_RST;
      refout_reg <= tpd_pkg::REFOUT_RST;
      divA_reg <= tpd_pkg::FBDIV_A_RST;
      divB_reg <= tpd_pkg::FBDIV_B_RST;
    end
    else if (clkEn)
    begin
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
      outSh_reg <= outSh_next;
      sdo_reg <= sdo_next;
      sdoOe_reg <= sdoOe_next;
      stamp_reg <= stamp_next;
      refout_reg <= refout_next;
      divA_reg <= divA_next;
      divB_reg <= divB_next;
    end
  end

  // Output controls and the divider settings the loop actually uses.
  logic [7:0] actA_reg;
  logic [7:0] actA_next;
  logic [7:0] actB_reg;
  logic [7:0] actB_next;
  logic       recv_reg;
  logic       pecl_reg;
  logic       bias_reg;
  logic       refo_reg;
  logic       recv_next;
  logic       pecl_next;
  logic       bias_next;
  logic       refo_next;

  always_comb
  begin
    recv_next = stamp_reg[tpd_pkg::RECV_ON_BIT];
    pecl_next = stamp_reg[tpd_pkg::PECL_BIT];
    bias_next = !stamp_reg[tpd_pkg::PECL_BIT];
    refo_next = refout_reg[tpd_pkg::REFOUT_EN_BIT] && pllEnable;
    // Frozen under loop reset; a divider rewrite with loop reset low reaches the running chain a cycle later.
    actA_next = synthLoopReset ? actA_reg : divA_reg;
    actB_next = synthLoopReset ? actB_reg : divB_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      recv_reg <= 1'b0;
      pecl_reg <= 1'b0;
      bias_reg <= 1'b1;
      refo_reg <= 1'b0;
      actA_reg <= tpd_pkg::FBDIV_A_RST;
      actB_reg <= tpd_pkg::FBDIV_B_RST;
    end
    else if (clkEn)
    begin
      recv_reg <= recv_next;
      pecl_reg <= pecl_next;
      bias_reg <= bias_next;
      refo_reg <= refo_next;
      actA_reg <= actA_next;
      actB_reg <= actB_next;
    end
  end

  // Software is trusted to hold loop reset across divider writes; see the freeze above.
  tpd_fb_divider u_div (
    .clk          (clk),
    .resetn       (resetn),
    .clkEn        (clkEn),
    .holdReset    (synthLoopReset),
    .vSel         (actA_reg[tpd_pkg::VDIV_LSB +: 2]),
    .pSel         (actA_reg[tpd_pkg::PDIV_LSB +: 2]),
    .nDiv         (actB_reg[tpd_pkg::NDIV_LSB +: 6]),
    .sampleTick   (sampleTick),
    .feedbackTick (feedbackTick)
  );

  assign spiSdo = sdo_reg;
  assign spiSdoOe = sdoOe_reg;
  assign stampReceiverOn = recv_reg;
  assign stampPeclModeSel = pecl_reg;
  assign stampSelfBiasOn = bias_reg;
  assign refoutEnable = refo_reg;

  chk_recv_follow: assert property (@(posedge clk) disable iff (!resetn)
    clkEn |=> (stampReceiverOn == $past(stamp_reg[0])))
    else $error("Receiver enable does not follow control bit 0.");

  chk_pecl_bias: assert property (@(posedge clk) disable iff (!resetn)
    (stampPeclModeSel != stampSelfBiasOn) and (clkEn |=> stampPeclModeSel == $past(stamp_reg[1])))
    else $error("PECL mode and self-bias disagree.");

  chk_refout_gate: assert property (@(posedge clk) disable iff (!resetn)
    clkEn |=> (refoutEnable == $past(refout_reg[0] && pllEnable)))
    else $error("Reference output does not follow enable and PLL.");

  chk_refout_reset: assert property (@(posedge clk)
    (!resetn && clkEn) |=> (refout_reg == 8'h01 && !refoutEnable))
    else $error("Reference enable not set after reset.");

  chk_hold_apply: assert property (@(posedge clk) disable iff (!resetn)
    (synthLoopReset && clkEn) |=> (actA_reg == $past(actA_reg) && actB_reg == $past(actB_reg)))
    else $error("Divider settings changed under loop reset.");

  cov_write_frame: cover property (@(posedge clk) disable iff (!resetn)
    $changed(divA_reg));
  cov_read_frame: cover property (@(posedge clk) disable iff (!resetn)
    $rose(spiSdoOe));
  cov_refout_on: cover property (@(posedge clk) disable iff (!resetn)
    $rose(refoutEnable));

endmodule
`default_nettype wire

// File: testbench/test_tpd_regs.sv
// Self-checking bench for the timestamp, reference output and feedback divider register bank.
`timescale 1ns/1ps
`default_nettype none
module test_tpd_regs;
  typedef struct {string name; logic [7:0] exp;} tpd_note_s;
  logic      clk;
  logic      resetn;
  logic      clkEn;
  logic      spiSclk;
  logic      spiSelN;
  logic      spiSdi;
  logic      pllEnable;
  logic      synthLoopReset;
  logic      spiSdo;
  logic      spiSdoOe;
  logic      stampReceiverOn;
  logic      stampPeclModeSel;
  logic      stampSelfBiasOn;
  logic      refoutEnable;
  logic      sampleTick;
  logic      feedbackTick;
  int        fail_count = 0;
  int        n_tests    = 0;
  int        tickDuring = 0;
  bit        holdCheck  = 0;
  tpd_note_s expQ[$];
  int        vTab[3] = '{5, 4, 3};
  int        pTab[3] = '{1, 2, 4};

  tpd_regs uut (
    .clk              (clk),
    .resetn           (resetn),
    .clkEn            (clkEn),
    .spiSclk          (spiSclk),
    .spiSelN          (spiSelN),
    .spiSdi           (spiSdi),
    .spiSdo           (spiSdo),
    .spiSdoOe         (spiSdoOe),
    .pllEnable        (pllEnable),
    .synthLoopReset   (synthLoopReset),
    .stampReceiverOn  (stampReceiverOn),
    .stampPeclModeSel (stampPeclModeSel),
    .stampSelfBiasOn  (stampSelfBiasOn),
    .refoutEnable     (refoutEnable),
    .sampleTick       (sampleTick),
    .feedbackTick     (feedbackTick)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Every drive lands 1 ns after a rising edge so no sampling race is possible.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // The serial clock half period is 5 system clocks, above the synchroniser minimum.
  task automatic spi(input logic rw, input logic [14:0] addr, input logic [7:0] data);
    logic [23:0] frame;
    frame = {rw, addr, data};
    spiSelN = 1'b0;
    step(5);
    for (int i = 23; i >= 0; i--)
    begin
      spiSdi = frame[i];
      step(5);
      spiSclk = 1'b1;
      step(5);
      spiSclk = 1'b0;
    end
    spiSdi = 1'($urandom);
    step(5);
    spiSelN = 1'b1;
    step(8);
  endtask

  task automatic wr(input logic [14:0] addr, input logic [7:0] data);
    spi(1'b0, addr, data);
  endtask

  task automatic rd(input logic [14:0] addr, input logic [7:0] exp, input string name);
    expQ.push_back('{name, exp});
    spi(1'b1, addr, 8'($urandom));
  endtask

  // Gap between two ticks: clock cycles, or sample ticks when measuring the feedback tick.
  task automatic gap(input bit fb, output int g);
    g = 0;
    for (int k = 0; k < 5000; k++)
    begin
      @(negedge clk);
      if ((fb ? feedbackTick : sampleTick) === 1'b1)
        break;
    end
    for (int k = 0; k < 5000; k++)
    begin
      @(negedge clk);
      g = g + (fb ? int'(sampleTick === 1'b1) : 1);
      if ((fb ? feedbackTick : sampleTick) === 1'b1)
        break;
    end
    step(1);
  endtask

  task automatic setdiv(input logic [7:0] a, input logic [7:0] b);
    synthLoopReset = 1'b1;
    step(2);
    holdCheck = 1'b1;
    wr(tpd_pkg::FBDIV_A_ADDR, a);
    wr(tpd_pkg::FBDIV_B_ADDR, b);
    holdCheck = 1'b0;
    synthLoopReset = 1'b0;
    step(2);
    check("tickHeld", 8'(tickDuring), 8'h00);
    tickDuring = 0;
  endtask

  always @(negedge clk)
    if (holdCheck && (sampleTick === 1'b1 || feedbackTick === 1'b1))
      tickDuring++;

  // Collects the read byte at serial rising edges 17 to 24 and compares it with the oldest note.
  initial
  begin : watchOut
    logic [7:0] bits;
    int         cnt;
    logic       rw;
    tpd_note_s  note;
    forever
    begin
      @(negedge spiSelN);
      cnt = 0;
      rw = 1'b0;
      bits = 8'h00;
      while (spiSelN === 1'b0)
      begin
        @(posedge spiSclk or posedge spiSelN);
        if (spiSelN === 1'b0)
        begin
          cnt++;
          if (cnt == 1)
            rw = spiSdi;
          if (cnt == 17)
            check("sdoOe", {7'h0, spiSdoOe}, {7'h0, rw});
          if (cnt > 16)
            bits = {bits[6:0], spiSdo};
        end
      end
      if (rw === 1'b1 && cnt == 24)
      begin
        if (expQ.size() == 0)
          check("unexpectedRead", bits, 8'h00);
        else
        begin
          note = expQ.pop_front();
          check(note.name, bits, note.exp);
        end
      end
    end
  end

  initial
  begin
    #(5 * 60000);
    fail_count++;
    $display("[FAIL] watchdog expected completion seen hang");
    end_of_test();
  end

  initial
  begin
    int         g;
    logic [5:0] nVal;
    void'($urandom(32'hcfc9));
    clkEn = 1'b1;
    resetn = 1'b0;
    spiSclk = 1'b0;
    spiSelN = 1'b1;
    spiSdi = 1'b0;
    pllEnable = 1'b1;
    synthLoopReset = 1'b0;
    step(4);
    resetn = 1'b1;
    check("selfBias", {7'h0, stampSelfBiasOn}, 8'h01);
    check("recvOn", {7'h0, stampReceiverOn}, 8'h00);
    step(2);
    check("refoutOn", {7'h0, refoutEnable}, 8'h01);
    rd(tpd_pkg::STAMP_CTRL_ADDR, tpd_pkg::STAMP_CTRL_RST, "stampCtrl");
    rd(tpd_pkg::REFOUT_ADDR, tpd_pkg::REFOUT_RST, "refoutCtrl");
    rd(tpd_pkg::FBDIV_A_ADDR, tpd_pkg::FBDIV_A_RST, "divA");
    rd(tpd_pkg::FBDIV_B_ADDR, tpd_pkg::FBDIV_B_RST, "divB");
    rd(15'h003f, tpd_pkg::READ_UNMAPPED, "unmapped");
    gap(1'b0, g);
    check("defSample", 8'(g), 8'h05);
    gap(1'b1, g);
    check("defFeedback", 8'(g), 8'h20);
    for (int c = 0; c < 4; c++)
    begin
      wr(tpd_pkg::STAMP_CTRL_ADDR, 8'(c));
      check("recvOn", {7'h0, stampReceiverOn}, {7'h0, c[0]});
      check("peclSel", {7'h0, stampPeclModeSel}, {7'h0, c[1]});
      check("selfBias", {7'h0, stampSelfBiasOn}, {7'h0, !c[1]});
      rd(tpd_pkg::STAMP_CTRL_ADDR, 8'(c), "stampCtrl");
    end
    // A frame sent while the clock enable is low must leave every register alone.
    clkEn = 1'b0;
    wr(tpd_pkg::STAMP_CTRL_ADDR, 8'h00);
    clkEn = 1'b1;
    step(2);
    check("frozenRecv", {7'h0, stampReceiverOn}, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      wr(tpd_pkg::REFOUT_ADDR, {7'h0, c[0]});
      pllEnable = c[1];
      step(2);
      check("refoutOn", {7'h0, refoutEnable}, {7'h0, c[0] & c[1]});
    end
    pllEnable = 1'b1;
    for (int v = 0; v < 3; v++)
      for (int p = 0; p < 3; p++)
      begin
        setdiv({4'h0, 2'(p), 2'(v)}, 8'h01);
        gap(1'b0, g);
        check("samplePeriod", 8'(g), 8'(vTab[v] * pTab[p]));
      end
    for (int t = 0; t < 3; t++)
    begin
      nVal = (t == 0) ? 6'h01 : (t == 1) ? 6'h3f : 6'(1 + $urandom % 62);
      setdiv(8'h00, {2'h0, nVal});
      rd(tpd_pkg::FBDIV_B_ADDR, {2'h0, nVal}, "divB");
      gap(1'b1, g);
      check("feedbackPeriod", 8'(g), {2'h0, nVal});
    end
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    check("recvOn", {7'h0, stampReceiverOn}, 8'h00);
    rd(tpd_pkg::STAMP_CTRL_ADDR, tpd_pkg::STAMP_CTRL_RST, "stampCtrl");
    check("pendingReads", 8'(expQ.size()), 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
